//--- rtl/timer_channel_capture_compare_pwm.sv
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ns

module timer_channel_capture_compare_pwm
    import timer_channel_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic debug_halt_mode_i,
    input wire logic channel_pin_i,
    output logic channel_pin_o,
    output logic channel_pin_oe_o,
    output logic channel_pin_timer_ctrl_o,
    output logic channel_irq_o
);
    import timer_channel_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] tsc;
        logic [7:0] csc;
        logic [15:0] count;
        logic [6:0] prescaler;
        logic [15:0] value;
        logic [15:0] value_buf;
        logic buf_high_done;
        logic buf_low_done;
        logic load_pending;
        logic [7:0] count_latch;
        logic count_latched;
        logic [7:0] value_latch;
        logic value_latched;
        logic clear_armed;
        logic pin_meta;
        logic pin_sync;
        logic pin_prev;
        logic pin_out;
        logic pin_oe;
        logic pin_ctrl;
        logic irq;
        logic [7:0] rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Mode decode, shared by pin and flag logic
    function automatic channel_mode_t decode_mode(input logic [7:0] tsc, input logic [7:0] csc);
        channel_mode_t m;
        m = MODE_CAPTURE;
        if (tsc[CENTER_ALIGN_SELECT_BIT])
        begin
            m = MODE_CENTER;
        end
        else if (csc[MODE_SELECT_HIGH_BIT])
        begin
            m = MODE_EDGE_PWM;
        end
        else if (csc[MODE_SELECT_LOW_BIT])
        begin
            m = MODE_COMPARE;
        end
        return m;
    endfunction

    // Prescaler terminal count for divide by 2^ps
    function automatic logic [6:0] prescale_top(input logic [2:0] ps);
        return 7'((8'h01 << ps) - 8'h01);
    endfunction

    channel_mode_t mode;
    logic [1:0] edge_level;
    logic [1:0] clock_source;
    logic tick;
    logic [15:0] count_inc;
    logic match;
    logic rise;
    logic fall;
    logic capture;
    logic event_set;
    logic wr_tsc;
    logic wr_cnt;
    logic wr_csc;
    logic wr_vh;
    logic wr_vl;
    logic rd_cnt_h;
    logic rd_cnt_l;
    logic rd_vh;
    logic rd_vl;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb
    begin
        state_next = state_reg;
        mode = decode_mode(state_reg.tsc, state_reg.csc);
        edge_level = state_reg.csc[EDGE_LEVEL_HIGH_BIT:EDGE_LEVEL_LOW_BIT];
        clock_source = state_reg.tsc[CLOCK_SOURCE_HIGH_BIT:CLOCK_SOURCE_LOW_BIT];
        wr_tsc = 1'b0;
        wr_cnt = 1'b0;
        wr_csc = 1'b0;
        wr_vh = 1'b0;
        wr_vl = 1'b0;
        rd_cnt_h = 1'b0;
        rd_cnt_l = 1'b0;
        rd_vh = 1'b0;
        rd_vl = 1'b0;

        // Address decode; unmapped offsets read as zero
        if (reg_addr_i == TIMER_STATUS_CONTROL_OFS)
        begin
            wr_tsc = reg_wr_i;
        end
        else if (reg_addr_i == COUNTER_HIGH_BYTE_OFS)
        begin
            wr_cnt = reg_wr_i;
            rd_cnt_h = reg_rd_i;
        end
        else if (reg_addr_i == COUNTER_LOW_BYTE_OFS)
        begin
            wr_cnt = reg_wr_i;
            rd_cnt_l = reg_rd_i;
        end
        else if (reg_addr_i == CHANNEL_STATUS_CONTROL_OFS)
        begin
            wr_csc = reg_wr_i;
        end
        else if (reg_addr_i == CHANNEL_VALUE_HIGH_OFS)
        begin
            wr_vh = reg_wr_i;
            rd_vh = reg_rd_i;
        end
        else if (reg_addr_i == CHANNEL_VALUE_LOW_OFS)
        begin
            wr_vl = reg_wr_i;
            rd_vl = reg_rd_i;
        end

        // two-stage pin synchroniser, edge seen on the second stage
        state_next.pin_meta = channel_pin_i;
        state_next.pin_sync = state_reg.pin_meta;
        state_next.pin_prev = state_reg.pin_sync;
        rise = state_reg.pin_sync & ~state_reg.pin_prev;
        fall = ~state_reg.pin_sync & state_reg.pin_prev;

        // Counter frozen in debug halt and with no clock source
        tick = 1'b0;
        if (clock_source != 2'b00 && !debug_halt_mode_i)
        begin
            if (state_reg.prescaler == prescale_top(state_reg.tsc[PRESCALE_MSB:0]))
            begin
                tick = 1'b1;
                state_next.prescaler = PRESCALER_RST;
            end
            else
            begin
                state_next.prescaler = state_reg.prescaler + 7'h01;
            end
        end
        count_inc = state_reg.count + 16'h0001;
        if (tick)
        begin
            state_next.count = count_inc;
        end
        // any counter byte write clears counter and prescaler
        if (wr_cnt)
        begin
            state_next.count = COUNTER_RST;
            state_next.prescaler = PRESCALER_RST;
        end

        capture = (mode == MODE_CAPTURE) && ((edge_level == 2'b01 && rise)
            || (edge_level == 2'b10 && fall) || (edge_level == 2'b11 && (rise || fall)));
        match = tick && (count_inc == state_reg.value);

        // match event, none for 0% duty in PWM
        event_set = capture || (match && (mode == MODE_COMPARE
            || (mode == MODE_EDGE_PWM && state_reg.value != COUNTER_ZERO)));
        if (capture)
        begin
            state_next.value = state_reg.count;
        end

        // Channel status/control write; flag bit handled below
        if (wr_csc)
        begin
            state_next.csc[6:0] = reg_wdata_i[6:0];
            // Pending value bytes are cancelled
            state_next.buf_high_done = 1'b0;
            state_next.buf_low_done = 1'b0;
            state_next.load_pending = 1'b0;
            state_next.value_latched = 1'b0;
        end
        if (wr_tsc)
        begin
            state_next.tsc = {2'b00, reg_wdata_i[5:0]};
        end

        // read with flag set arms the clear
        if (reg_rd_i && reg_addr_i == CHANNEL_STATUS_CONTROL_OFS && state_reg.csc[CHANNEL_EVENT_FLAG_BIT])
        begin
            state_next.clear_armed = 1'b1;
        end
        // only a zero write after arming clears; one is ignored
        if (wr_csc && !reg_wdata_i[CHANNEL_EVENT_FLAG_BIT] && state_reg.clear_armed)
        begin
            state_next.csc[CHANNEL_EVENT_FLAG_BIT] = 1'b0;
            state_next.clear_armed = 1'b0;
        end
        // a new event wins and restarts the sequence
        if (event_set)
        begin
            state_next.csc[CHANNEL_EVENT_FLAG_BIT] = 1'b1;
            state_next.clear_armed = 1'b0;
        end

        // value writes ignored in capture mode
        if (mode != MODE_CAPTURE)
        begin
            if (wr_vh)
            begin
                state_next.value_buf[15:8] = reg_wdata_i;
                state_next.buf_high_done = 1'b1;
            end
            if (wr_vl)
            begin
                state_next.value_buf[7:0] = reg_wdata_i;
                state_next.buf_low_done = 1'b1;
            end
        end
        // Both bytes in: load now without clock, else defer to a tick
        if (state_reg.buf_high_done && state_reg.buf_low_done)
        begin
            state_next.buf_high_done = 1'b0;
            state_next.buf_low_done = 1'b0;
            if (clock_source == 2'b00)
            begin
                state_next.value = state_reg.value_buf;
            end
            else
            begin
                state_next.load_pending = 1'b1;
            end
        end
        // compare loads on the next tick; PWM at period end
        if (state_reg.load_pending && tick
            && (mode != MODE_EDGE_PWM || state_reg.count == COUNTER_TERMINAL))
        begin
            state_next.value = state_reg.value_buf;
            state_next.load_pending = 1'b0;
        end

        // edge bits 00 hand the pin back to general I/O
        state_next.pin_ctrl = (edge_level != 2'b00);
        // Edge PWM and compare force the pin to output; center mode never drives it
        state_next.pin_oe = (edge_level != 2'b00) && (mode == MODE_COMPARE || mode == MODE_EDGE_PWM);
        if (mode == MODE_EDGE_PWM && edge_level != 2'b00)
        begin
            if (tick && count_inc == COUNTER_ZERO)
            begin
                state_next.pin_out = ~edge_level[0];
            end
            if (match)
            begin
                state_next.pin_out = edge_level[0];
            end
        end
        // toggle, clear or set on match
        else if (mode == MODE_COMPARE && match)
        begin
            if (edge_level == 2'b01)
            begin
                state_next.pin_out = ~state_reg.pin_out;
            end
            else if (edge_level == 2'b10)
            begin
                state_next.pin_out = 1'b0;
            end
            else if (edge_level == 2'b11)
            begin
                state_next.pin_out = 1'b1;
            end
        end

        // Counter reads: the first byte latches the other half
        state_next.rdata = 8'h00;
        if (rd_cnt_h || rd_cnt_l)
        begin
            if (debug_halt_mode_i)
            begin
                state_next.rdata = rd_cnt_h ? state_reg.count[15:8] : state_reg.count[7:0];
            end
            else if (state_reg.count_latched)
            begin
                state_next.rdata = state_reg.count_latch;
                state_next.count_latched = 1'b0;
            end
            else
            begin
                state_next.rdata = rd_cnt_h ? state_reg.count[15:8] : state_reg.count[7:0];
                state_next.count_latch = rd_cnt_h ? state_reg.count[7:0] : state_reg.count[15:8];
                state_next.count_latched = 1'b1;
            end
        end
        // counter latch reset by these writes
        if (wr_cnt || (wr_tsc && debug_halt_mode_i))
        begin
            state_next.count_latched = 1'b0;
        end

        // Channel value reads, same scheme as the counter
        if (rd_vh || rd_vl)
        begin
            if (debug_halt_mode_i)
            begin
                state_next.rdata = rd_vh ? state_reg.value[15:8] : state_reg.value[7:0];
            end
            else if (state_reg.value_latched)
            begin
                state_next.rdata = state_reg.value_latch;
                state_next.value_latched = 1'b0;
            end
            else
            begin
                state_next.rdata = rd_vh ? state_reg.value[15:8] : state_reg.value[7:0];
                state_next.value_latch = rd_vh ? state_reg.value[7:0] : state_reg.value[15:8];
                state_next.value_latched = 1'b1;
            end
        end
        if (reg_rd_i && reg_addr_i == TIMER_STATUS_CONTROL_OFS)
        begin
            state_next.rdata = state_reg.tsc;
        end
        if (reg_rd_i && reg_addr_i == CHANNEL_STATUS_CONTROL_OFS)
        begin
            state_next.rdata = state_reg.csc;
        end

        state_next.irq = state_next.csc[CHANNEL_EVENT_FLAG_BIT] & state_next.csc[CHANNEL_IRQ_ENABLE_BIT];
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_reg <= '0;
            state_reg.tsc <= TIMER_STATUS_CONTROL_RST;
            // capture mode, pin released, flag and enable clear
            state_reg.csc <= CHANNEL_STATUS_CONTROL_RST;
            state_reg.count <= COUNTER_RST;
            state_reg.value <= CHANNEL_VALUE_RST;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata_o = state_reg.rdata;
    assign channel_pin_o = state_reg.pin_out;
    assign channel_pin_oe_o = state_reg.pin_oe;
    assign channel_pin_timer_ctrl_o = state_reg.pin_ctrl;
    assign channel_irq_o = state_reg.irq;

endmodule

//--- rtl/timer_channel_pkg.sv
package timer_channel_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [3:0] TIMER_STATUS_CONTROL_OFS = 4'h0;
    localparam logic [3:0] COUNTER_HIGH_BYTE_OFS = 4'h1;
    localparam logic [3:0] COUNTER_LOW_BYTE_OFS = 4'h2;
    localparam logic [3:0] CHANNEL_STATUS_CONTROL_OFS = 4'h3;
    localparam logic [3:0] CHANNEL_VALUE_HIGH_OFS = 4'h4;
    localparam logic [3:0] CHANNEL_VALUE_LOW_OFS = 4'h5;

    // ****************************************
    // Field positions
    // ****************************************
    // Timer status/control
    localparam int CENTER_ALIGN_SELECT_BIT = 5;
    localparam int CLOCK_SOURCE_HIGH_BIT = 4;
    localparam int CLOCK_SOURCE_LOW_BIT = 3;
    localparam int PRESCALE_MSB = 2;
    // Channel status/control
    localparam int CHANNEL_EVENT_FLAG_BIT = 7;
    localparam int CHANNEL_IRQ_ENABLE_BIT = 6;
    localparam int MODE_SELECT_HIGH_BIT = 5;
    localparam int MODE_SELECT_LOW_BIT = 4;
    localparam int EDGE_LEVEL_HIGH_BIT = 3;
    localparam int EDGE_LEVEL_LOW_BIT = 2;

    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [7:0] TIMER_STATUS_CONTROL_RST = 8'h00;
    localparam logic [7:0] CHANNEL_STATUS_CONTROL_RST = 8'h00;
    localparam logic [15:0] COUNTER_RST = 16'h0000;
    localparam logic [15:0] CHANNEL_VALUE_RST = 16'h0000;
    localparam logic [15:0] COUNTER_ZERO = 16'h0000;
    localparam logic [15:0] COUNTER_TERMINAL = 16'hffff;
    localparam logic [6:0] PRESCALER_RST = 7'h00;

    // Channel operating mode, one-hot
    typedef enum logic [3:0] {
        MODE_CAPTURE = 4'b0001,
        MODE_COMPARE = 4'b0010,
        MODE_EDGE_PWM = 4'b0100,
        MODE_CENTER = 4'b1000
    } channel_mode_t;

endpackage

//--- test/pin_source.sv
`timescale 1ns/1ns

// ****************************************
// Push-pull source on the channel pin
// ****************************************
module pin_source
(
    input wire logic clk_i,
    input wire logic level_i,
    output logic pin_o = 1'h0
);
    // level held from edge to edge
    // Moves only at a clock edge, so each new level stays put for the cycles the bench waits
    always_ff @(posedge clk_i)
    begin
        pin_o <= level_i;
    end
endmodule

//--- test/timer_channel_props.sv
`timescale 1ns/1ns

// ****************************************
// Port checker
// ****************************************
module timer_channel_props
    import timer_channel_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic debug_halt_mode_i,
    input wire logic channel_pin_i,
    input wire logic channel_pin_o,
    input wire logic channel_pin_oe_o,
    input wire logic channel_pin_timer_ctrl_o,
    input wire logic channel_irq_o
);
    logic [7:0] csc_q;
    logic center_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // Shadow of the control bits software wrote
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            csc_q <= 8'h00;
            center_q <= 1'h0;
        end
        else if (reg_wr_i && reg_addr_i == CHANNEL_STATUS_CONTROL_OFS)
            csc_q <= reg_wdata_i;
        else if (reg_wr_i && reg_addr_i == TIMER_STATUS_CONTROL_OFS)
            center_q <= reg_wdata_i[CENTER_ALIGN_SELECT_BIT];
    end

    // A control write followed by a quiet cycle, so registered outputs have settled
    sequence csc_wr;
        reg_wr_i && reg_addr_i == CHANNEL_STATUS_CONTROL_OFS;
    endsequence
    sequence csc_settled;
        csc_wr ##1 !reg_wr_i;
    endsequence

    pin_owner_a: assert property (csc_settled |=> channel_pin_timer_ctrl_o == (csc_q[3:2] != 2'h0))
        else $error("pin ownership does not follow edge bits");
    pwm_drive_a: assert property (csc_settled |=> (csc_q[5] && csc_q[3:2] != 2'h0 && !center_q) -> channel_pin_oe_o)
        else $error("edge pwm does not drive the pin");
    capture_float_a: assert property (csc_settled |=> (csc_q[5:4] == 2'h0) -> !channel_pin_oe_o)
        else $error("capture mode drives the pin");
    reset_quiet_a: assert property (disable iff (1'h0) sys_rst_i |=>
        !channel_pin_oe_o && !channel_irq_o && !channel_pin_timer_ctrl_o && reg_rdata_o == 8'h00)
        else $error("outputs not quiet after reset");
    irq_mask_a: assert property (csc_wr ##0 !reg_wdata_i[6] ##1 !reg_wr_i |=> !channel_irq_o)
        else $error("request stays with enable cleared");
    irq_enable_a: assert property (channel_irq_o && $stable(csc_q) |-> csc_q[6])
        else $error("request without enable");
    irq_flag_a: assert property (reg_rd_i && reg_addr_i == CHANNEL_STATUS_CONTROL_OFS && channel_irq_o
        |=> reg_rdata_o[7])
        else $error("request without flag");
    csc_readback_a: assert property (reg_rd_i && reg_addr_i == CHANNEL_STATUS_CONTROL_OFS
        |=> reg_rdata_o[6:2] == csc_q[6:2])
        else $error("control bits read back wrong");
endmodule

bind timer_channel_capture_compare_pwm timer_channel_props props_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .debug_halt_mode_i(debug_halt_mode_i), .channel_pin_i(channel_pin_i),
    .channel_pin_o(channel_pin_o), .channel_pin_oe_o(channel_pin_oe_o),
    .channel_pin_timer_ctrl_o(channel_pin_timer_ctrl_o), .channel_irq_o(channel_irq_o));

//--- test/tb.sv
`timescale 1ns/1ns

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end

module tb;
    import timer_channel_pkg::*;
    logic clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'h0;
    logic reg_rd_i = 1'h0;
    logic debug_halt_mode_i = 1'h0;
    logic pin_lvl = 1'h0;
    logic channel_pin_i;
    logic [7:0] reg_rdata_o;
    logic channel_pin_o;
    logic channel_pin_oe_o;
    logic channel_pin_timer_ctrl_o;
    logic channel_irq_o;
    int mismatches = 0;
    int checked = 0;

    timer_channel_capture_compare_pwm dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .debug_halt_mode_i(debug_halt_mode_i), .channel_pin_i(channel_pin_i), .channel_pin_o(channel_pin_o),
        .channel_pin_oe_o(channel_pin_oe_o), .channel_pin_timer_ctrl_o(channel_pin_timer_ctrl_o),
        .channel_irq_o(channel_irq_o));
    pin_source src_u (.clk_i(clk_i), .level_i(pin_lvl), .pin_o(channel_pin_i));

    // 10 MHz bus clock
    initial forever #50 clk_i = ~clk_i;

    // Waits leave 1 ns after the edge so outputs have settled
    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // One-cycle write strobe, then a gap so the strobe is never set twice in one step
    task wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge clk_i);
        reg_wr_i <= 1'h0;
        @(posedge clk_i);
    endtask

    // Read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a, input logic [7:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        @(posedge clk_i);
        reg_rd_i <= 1'h0;
        #1;
        `CHK(reg_rdata_o, e)
        @(posedge clk_i);
    endtask

    task complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Longest wait is one counter wrap of 65536 cycles
    initial
    begin
        repeat (99000) @(posedge clk_i);
        mismatches++;
        complete_run();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        logic [1:0] e;
        logic [7:0] m;
        int k;
        tick(4);
        sys_rst_i <= 1'h0;
        tick(1);
        rd(CHANNEL_STATUS_CONTROL_OFS, CHANNEL_STATUS_CONTROL_RST);
        rd(TIMER_STATUS_CONTROL_OFS, TIMER_STATUS_CONTROL_RST);
        rd(4'hf, 8'h00);
        $display("test reset done");
        // Counter held at zero with no clock source, so captures latch zero
        wr(COUNTER_HIGH_BYTE_OFS, 8'h5a);
        for (int i = 1; i < 4; i++)
        begin
            e = i[1:0];
            wr(CHANNEL_STATUS_CONTROL_OFS, {4'h4, e, 2'h0});
            pin_lvl <= 1'h1;
            tick(6);
            `CHK(channel_irq_o, e[0])
            rd(CHANNEL_STATUS_CONTROL_OFS, {e[0], 3'h4, e, 2'h0});
            wr(CHANNEL_STATUS_CONTROL_OFS, {4'h4, e, 2'h0});
            pin_lvl <= 1'h0;
            tick(6);
            rd(CHANNEL_STATUS_CONTROL_OFS, {e[1], 3'h4, e, 2'h0});
            wr(CHANNEL_STATUS_CONTROL_OFS, {4'h4, e, 2'h0});
        end
        // New edge between the arming read and the zero write keeps the flag
        pin_lvl <= 1'h1;
        tick(6);
        rd(CHANNEL_STATUS_CONTROL_OFS, 8'hcc);
        pin_lvl <= 1'h0;
        tick(6);
        wr(CHANNEL_STATUS_CONTROL_OFS, 8'h4c);
        rd(CHANNEL_STATUS_CONTROL_OFS, 8'hcc);
        wr(CHANNEL_STATUS_CONTROL_OFS, 8'h4c);
        rd(CHANNEL_STATUS_CONTROL_OFS, 8'h4c);
        wr(CHANNEL_STATUS_CONTROL_OFS, 8'hcc);
        rd(CHANNEL_STATUS_CONTROL_OFS, 8'h4c);
        debug_halt_mode_i <= 1'h1;
        wr(CHANNEL_VALUE_HIGH_OFS, 8'h12);
        wr(CHANNEL_VALUE_LOW_OFS, 8'h34);
        rd(CHANNEL_VALUE_HIGH_OFS, 8'h00);
        rd(CHANNEL_VALUE_LOW_OFS, 8'h00);
        rd(COUNTER_LOW_BYTE_OFS, 8'h00);
        debug_halt_mode_i <= 1'h0;
        $display("test capture done");
        // Compare value loads at once while no clock source is selected
        wr(CHANNEL_STATUS_CONTROL_OFS, 8'h10);
        wr(CHANNEL_VALUE_HIGH_OFS, 8'h00);
        wr(CHANNEL_VALUE_LOW_OFS, 8'h05);
        rd(CHANNEL_VALUE_LOW_OFS, 8'h05);
        for (int i = 0; i < 4; i++)
        begin
            m = {4'h1, i[1:0], 2'h0};
            wr(TIMER_STATUS_CONTROL_OFS, 8'h00);
            wr(COUNTER_LOW_BYTE_OFS, 8'h00);
            wr(CHANNEL_STATUS_CONTROL_OFS, m);
            wr(TIMER_STATUS_CONTROL_OFS, 8'h08);
            tick(12);
            `CHK(channel_pin_oe_o, m[3:2] != 2'h0)
            if (m[3:2] != 2'h0)
                `CHK(channel_pin_o, m[2])
            rd(CHANNEL_STATUS_CONTROL_OFS, {1'h1, m[6:0]});
        end
        // Counter had run past 5; any byte write clears it
        wr(TIMER_STATUS_CONTROL_OFS, 8'h00);
        wr(COUNTER_HIGH_BYTE_OFS, 8'h77);
        rd(COUNTER_HIGH_BYTE_OFS, 8'h00);
        rd(COUNTER_LOW_BYTE_OFS, 8'h00);
        $display("test compare done");
        wr(CHANNEL_STATUS_CONTROL_OFS, 8'h24);
        wr(TIMER_STATUS_CONTROL_OFS, 8'h08);
        tick(12);
        `CHK(channel_pin_oe_o, 1'h1)
        `CHK(channel_pin_o, 1'h1)
        rd(CHANNEL_STATUS_CONTROL_OFS, 8'ha4);
        // Full wrap of the free-running counter, then the pulse again
        for (k = 0; k < 70000 && channel_pin_o === 1'h1; k++)
            tick(1);
        `CHK(channel_pin_o, 1'h0)
        tick(8);
        `CHK(channel_pin_o, 1'h1)
        $display("test pwm done");
        // High-true PWM: the match now drives the pin low
        wr(TIMER_STATUS_CONTROL_OFS, 8'h00);
        wr(CHANNEL_STATUS_CONTROL_OFS, 8'h28);
        wr(COUNTER_LOW_BYTE_OFS, 8'h00);
        wr(TIMER_STATUS_CONTROL_OFS, 8'h08);
        tick(12);
        `CHK(channel_pin_o, 1'h0)
        // Slow prescaler, so the buffered value waits for the next count
        wr(TIMER_STATUS_CONTROL_OFS, 8'h00);
        wr(CHANNEL_STATUS_CONTROL_OFS, 8'h10);
        wr(COUNTER_LOW_BYTE_OFS, 8'h00);
        wr(TIMER_STATUS_CONTROL_OFS, 8'h0f);
        wr(CHANNEL_VALUE_HIGH_OFS, 8'h12);
        wr(CHANNEL_VALUE_LOW_OFS, 8'h34);
        rd(CHANNEL_VALUE_LOW_OFS, 8'h05);
        rd(CHANNEL_VALUE_HIGH_OFS, 8'h00);
        tick(260);
        rd(CHANNEL_VALUE_LOW_OFS, 8'h34);
        // Control write drops the latched high byte
        wr(CHANNEL_STATUS_CONTROL_OFS, 8'h10);
        rd(CHANNEL_VALUE_LOW_OFS, 8'h34);
        $display("test buffer done");
        complete_run();
    end
endmodule
